// *** nic_pkg.sv ***
// Shared constants, types and state records of the nested interrupt unit.
package nic_pkg;

    // -------------------------------------------------------------------
    // Exception numbers and fixed ranks
    // -------------------------------------------------------------------
    localparam int NIC_LINES = 32;
    localparam int NIC_EXC_COUNT = 48;
    localparam logic [5:0] EXC_RESET = 6'h01;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_HARDFAULT = 6'h03;
    localparam logic [5:0] EXC_SVC = 6'h0B;
    localparam logic [5:0] EXC_PENDED_SERVICE_EXCEPTION = 6'h0E;
    localparam logic [5:0] EXC_TICK = 6'h0F;
    localparam logic [5:0] EXC_EXT_BASE = 6'h10;
    localparam logic [5:0] EXC_NONE = 6'h00;

    // Lower rank is more urgent: fixed -3,-2,-1 map to 0,1,2.
    localparam logic [2:0] RANK_RESET = 3'h0;
    localparam logic [2:0] RANK_NMI = 3'h1;
    localparam logic [2:0] RANK_HARDFAULT = 3'h2;
    localparam logic [2:0] RANK_CFG_BASE = 3'h3;
    localparam logic [2:0] RANK_THREAD = 3'h7;

    // -------------------------------------------------------------------
    // Priority fields
    // -------------------------------------------------------------------
    localparam int PRIO_FIELD_W = 8;
    localparam int PRIO_MSB = 7;
    localparam int PRIO_LSB = 6;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [3:0] PRIO_REG_SYS = 4'h8;
    localparam int SYS_BYTE_SVC = 0;
    localparam int SYS_BYTE_PENDED_SERVICE_EXCEPTION = 1;
    localparam int SYS_BYTE_TICK = 2;

    // -------------------------------------------------------------------
    // Line map, stacking and vector table
    // -------------------------------------------------------------------
    localparam logic [31:0] LINE_USED_MASK = 32'h360CFFFF;
    localparam logic [31:0] WAKE_MASK = 32'h160C303F;
    localparam logic [2:0] STACK_LAST = 3'h7;
    localparam logic [31:0] VEC_TABLE_BASE = 32'h00000000;
    localparam logic [31:0] VEC_SP_MAIN_ADDR = 32'h00000000;
    localparam int TICK_W = 24;
    localparam logic [23:0] TICK_ZERO = 24'h000000;
    localparam logic [23:0] TICK_ONE = 24'h000001;

    typedef enum logic [1:0] {
        NIC_IDLE,
        NIC_ENTRY,
        NIC_HANDLER,
        NIC_UNSTACK
    } nic_phase_type;

    typedef struct packed {
        logic enable;
        logic int_enable;
        logic [TICK_W-1:0] reload;
    } nic_tick_cfg_type;

    typedef struct packed {
        logic [TICK_W-1:0] cur;
        logic flag;
        logic pend;
    } nic_tick_state_type;

    typedef struct packed {
        logic wr;
        logic [3:0] idx;
        logic [31:0] data;
    } nic_prio_wr_type;

    typedef struct packed {
        logic handler_mode;
        logic [5:0] cur_exc;
        logic stack_req;
        logic unstack_req;
        logic [2:0] stack_word;
        logic vec_req;
        logic [31:0] vec_addr;
        logic entry_pulse;
        logic resume_pulse;
    } nic_core_out_type;

endpackage : nic_pkg

// *** nic_tick_timer.sv ***
// Down-counting system tick timer that pends the tick exception.
module nic_tick_timer
    import nic_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire nic_tick_cfg_type cfg,
    input wire logic cur_wr,
    input wire logic status_rd,
    output nic_tick_state_type st
);

    // -------------------------------------------------------------------
    // Counter state
    // -------------------------------------------------------------------
    nic_tick_state_type st_r;
    nic_tick_state_type st_nxt;
    logic wrap;

    // Counts down, reloads from zero, clears on any write of the value.
    always_comb begin
        st_nxt = st_r;
        wrap = cfg.enable && !cur_wr && (st_r.cur == TICK_ONE);
        if (cur_wr) begin
            st_nxt.cur = TICK_ZERO;
        end else if (cfg.enable) begin
            if (st_r.cur == TICK_ZERO) begin
                st_nxt.cur = cfg.reload;
            end else begin
                st_nxt.cur = st_r.cur - TICK_ONE;
            end
        end
        if (status_rd || cur_wr) begin
            st_nxt.flag = 1'b0;
        end
        if (wrap) begin
            st_nxt.flag = 1'b1;
        end
        st_nxt.pend = wrap && cfg.int_enable;
    end

    // Registers the counter record.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign st = st_r;

endmodule : nic_tick_timer

// *** nic_irq_ctrl.sv ***
// Nested vectored interrupt unit with its system tick timer.
//
// Notes on behaviour
// - Tick timer is a 24-bit down counter that wraps at zero.
// - Any write to the tick current value clears the counter.
// - Enabled counter counts to zero, then loads the reload value.
// - Tick wrap flag sets when the enabled counter counts down from one to zero.
// - Reading the tick status clears the wrap flag.
// - Reload value zero keeps the counter parked at zero.
// - Thirty-two external lines, each with one of four priorities.
// - Only a strictly more urgent request preempts the running handler.
// - Priority value 0 is most urgent, 3 least urgent.
// - All configurable priorities are zero after reset.
// - Reset, NMI and hard fault rank above every configurable level.
// - Fixed exception numbers; external lines use numbers 16 to 47.
// - Accepting an exception fetches its handler address from memory.
// - Vector address is four times the exception number.
// - Eight core registers are pushed while the vector is fetched.
// - Handler end pops the saved registers and resumes execution.
// - Pending work at handler end chains in without unstack and restack.
// - A more urgent arrival during entry swaps vectors without delay.
// - External lines follow the fixed source map; unused lines ignored.
// - Only the listed source classes may wake the chip.
// - Every exception handler runs in handler mode.
// - Enable and pending each have write-1 set and clear inputs.
// - Disabled lines still pend; active handlers stay active when disabled.
// - Priorities sit in 8-bit fields, four per 32-bit word.
// - Vector table sits at address zero; word zero is the stack pointer.
module nic_irq_ctrl
    import nic_pkg::*;
#(
    parameter int LINES = NIC_LINES
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [LINES-1:0] irq_line,
    input wire logic nmi_line,
    input wire logic hardfault_req,
    input wire logic svc_req,
    input wire logic pended_service_exception_set,
    input wire logic pended_service_exception_clr,
    input wire logic [LINES-1:0] enable_set,
    input wire logic [LINES-1:0] enable_clr,
    input wire logic [LINES-1:0] pending_set,
    input wire logic [LINES-1:0] pending_clr,
    input wire nic_prio_wr_type prio_wr,
    input wire logic [3:0] prio_rd_idx,
    input wire nic_tick_cfg_type tick_cfg,
    input wire logic tick_cur_wr,
    input wire logic tick_status_rd,
    input wire logic core_stack_ack,
    input wire logic core_vec_ack,
    input wire logic core_exc_return,
    output logic [LINES-1:0] enable_state,
    output logic [LINES-1:0] pending_state,
    output logic [31:0] prio_rdata,
    output logic wake_req,
    output nic_core_out_type core_out,
    output logic [TICK_W-1:0] tick_current,
    output logic tick_wrap_flag
);

    // -------------------------------------------------------------------
    // State record
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [LINES-1:0] sync1;
        logic [LINES-1:0] sync2;
        logic nmi_sync1;
        logic nmi_sync2;
        nic_phase_type phase;
        logic [LINES-1:0] en;
        logic [NIC_EXC_COUNT-1:0] pend;
        logic [NIC_EXC_COUNT-1:0] active;
        logic [LINES-1:0][1:0] ext_prio;
        logic [2:0][1:0] sys_prio;
        logic [5:0] sel;
        logic [2:0] sel_rank;
        logic stack_done;
        logic vec_done;
        logic [31:0] prio_rdata;
        logic wake;
        nic_core_out_type co;
    } nic_state_type;

    nic_state_type st_r;
    nic_state_type st_nxt;
    nic_tick_state_type tick_st;
    logic [2:0] rank [NIC_EXC_COUNT];
    logic best_valid;
    logic [5:0] best_num;
    logic [2:0] best_rank;
    logic [5:0] top_num;
    logic [2:0] exec_rank;
    logic [2:0] exec_after;
    logic [NIC_EXC_COUNT-1:0] cand;

    // Maps a two-bit configurable priority to an internal rank.
    function automatic logic [2:0] cfg_rank(input logic [1:0] p);
        cfg_rank = RANK_CFG_BASE + {1'b0, p};
    endfunction : cfg_rank

    // Builds a priority word; implemented bits sit at the top of each byte.
    function automatic logic [31:0] prio_word(input logic [3:0] idx,
                                              input nic_state_type s);
        logic [31:0] w;
        w = '0;
        for (int b = 0; b < 4; b++) begin
            if (idx == PRIO_REG_SYS) begin
                if (b < 3) begin
                    w[b*PRIO_FIELD_W+PRIO_LSB +: 2] = s.sys_prio[b];
                end
            end else if (idx < PRIO_REG_SYS) begin
                w[b*PRIO_FIELD_W+PRIO_LSB +: 2] = s.ext_prio[{idx[2:0],
                                                   2'(b)}];
            end
        end
        prio_word = w;
    endfunction : prio_word

    // -------------------------------------------------------------------
    // Tick timer
    // -------------------------------------------------------------------
    nic_tick_timer u_tick (
        .clock(clock),
        .rst_b(rst_b),
        .cfg(tick_cfg),
        .cur_wr(tick_cur_wr),
        .status_rd(tick_status_rd),
        .st(tick_st)
    );

    // -------------------------------------------------------------------
    // Arbitration
    // -------------------------------------------------------------------
    // Ranks every exception number; unused numbers never pend.
    always_comb begin
        for (int i = 0; i < NIC_EXC_COUNT; i++) begin
            rank[i] = RANK_THREAD;
        end
        rank[EXC_RESET] = RANK_RESET;
        rank[EXC_NMI] = RANK_NMI;
        rank[EXC_HARDFAULT] = RANK_HARDFAULT;
        rank[EXC_SVC] = cfg_rank(st_r.sys_prio[SYS_BYTE_SVC]);
        rank[EXC_PENDED_SERVICE_EXCEPTION] = cfg_rank(st_r.sys_prio[SYS_BYTE_PENDED_SERVICE_EXCEPTION]);
        rank[EXC_TICK] = cfg_rank(st_r.sys_prio[SYS_BYTE_TICK]);
        for (int i = 0; i < LINES; i++) begin
            rank[EXC_EXT_BASE + i] = cfg_rank(st_r.ext_prio[i]);
        end
    end

    // Picks the most urgent enabled pending exception and the running level.
    always_comb begin
        cand = st_r.pend & ~st_r.active;
        cand[EXC_EXT_BASE +: LINES] = st_r.pend[EXC_EXT_BASE +: LINES]
            & ~st_r.active[EXC_EXT_BASE +: LINES] & st_r.en;
        best_valid = 1'b0;
        best_num = EXC_NONE;
        best_rank = RANK_THREAD;
        top_num = EXC_NONE;
        exec_rank = RANK_THREAD;
        exec_after = RANK_THREAD;
        for (int i = 0; i < NIC_EXC_COUNT; i++) begin
            if (cand[i] && rank[i] < best_rank) begin
                best_valid = 1'b1;
                best_num = 6'(i);
                best_rank = rank[i];
            end
            if (st_r.active[i] && rank[i] < exec_rank) begin
                top_num = 6'(i);
                exec_rank = rank[i];
            end
        end
        for (int i = 0; i < NIC_EXC_COUNT; i++) begin
            if (st_r.active[i] && 6'(i) != top_num
                && rank[i] < exec_after) begin
                exec_after = rank[i];
            end
        end
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    // Updates pending, enables, priorities and the entry and exit sequence.
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = irq_line;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.nmi_sync1 = nmi_line;
        st_nxt.nmi_sync2 = st_r.nmi_sync1;
        st_nxt.co.entry_pulse = 1'b0;
        st_nxt.co.resume_pulse = 1'b0;

        // Enable and pending bits: the set side wins over a clear.
        st_nxt.en = (st_r.en & ~enable_clr) | enable_set;
        st_nxt.pend[EXC_EXT_BASE +: LINES] = ((st_r.pend[EXC_EXT_BASE +:
            LINES] & ~pending_clr) | pending_set)
            & LINE_USED_MASK;
        if (pended_service_exception_clr) begin
            st_nxt.pend[EXC_PENDED_SERVICE_EXCEPTION] = 1'b0;
        end

        // Priority writes land in the top two bits of each field.
        if (prio_wr.wr) begin
            for (int b = 0; b < 4; b++) begin
                if (prio_wr.idx == PRIO_REG_SYS) begin
                    if (b < 3) begin
                        st_nxt.sys_prio[b] = prio_wr.data[b*PRIO_FIELD_W+
                                                          PRIO_MSB -: 2];
                    end
                end else if (prio_wr.idx < PRIO_REG_SYS) begin
                    st_nxt.ext_prio[{prio_wr.idx[2:0], 2'(b)}] =
                        prio_wr.data[b*PRIO_FIELD_W+PRIO_MSB -: 2];
                end
            end
        end
        st_nxt.prio_rdata = prio_word(prio_rd_idx, st_r);
        st_nxt.wake = |(st_r.pend[EXC_EXT_BASE +: LINES] & WAKE_MASK);

        unique case (st_r.phase)
            NIC_IDLE, NIC_HANDLER: begin
                if (best_valid && best_rank < exec_rank) begin
                    st_nxt.phase = NIC_ENTRY;
                    st_nxt.sel = best_num;
                    st_nxt.sel_rank = best_rank;
                    st_nxt.stack_done = 1'b0;
                    st_nxt.vec_done = 1'b0;
                    st_nxt.co.stack_req = 1'b1;
                    st_nxt.co.stack_word = '0;
                    st_nxt.co.vec_req = 1'b1;
                    st_nxt.co.vec_addr = VEC_TABLE_BASE
                        + {24'h000000, best_num, 2'b00};
                end else if (st_r.phase == NIC_HANDLER && core_exc_return) begin
                    st_nxt.active[top_num] = 1'b0;
                    if (best_valid && best_rank < exec_after) begin
                        st_nxt.phase = NIC_ENTRY;
                        st_nxt.sel = best_num;
                        st_nxt.sel_rank = best_rank;
                        st_nxt.stack_done = 1'b1;
                        st_nxt.vec_done = 1'b0;
                        st_nxt.co.vec_req = 1'b1;
                        st_nxt.co.vec_addr = VEC_TABLE_BASE
                            + {24'h000000, best_num, 2'b00};
                    end else begin
                        st_nxt.phase = NIC_UNSTACK;
                        st_nxt.co.unstack_req = 1'b1;
                        st_nxt.co.stack_word = '0;
                    end
                end
            end
            NIC_ENTRY: begin
                if (core_stack_ack && !st_r.stack_done) begin
                    st_nxt.co.stack_word = st_r.co.stack_word + 3'h1;
                    if (st_r.co.stack_word == STACK_LAST) begin
                        st_nxt.stack_done = 1'b1;
                        st_nxt.co.stack_req = 1'b0;
                    end
                end
                if (core_vec_ack && !st_r.vec_done) begin
                    st_nxt.vec_done = 1'b1;
                    st_nxt.co.vec_req = 1'b0;
                end
                if (best_valid && best_rank < st_r.sel_rank) begin
                    st_nxt.sel = best_num;
                    st_nxt.sel_rank = best_rank;
                    st_nxt.vec_done = 1'b0;
                    st_nxt.co.vec_req = 1'b1;
                    st_nxt.co.vec_addr = VEC_TABLE_BASE
                        + {24'h000000, best_num, 2'b00};
                end else if (st_r.stack_done && st_r.vec_done) begin
                    st_nxt.phase = NIC_HANDLER;
                    st_nxt.active[st_r.sel] = 1'b1;
                    st_nxt.pend[st_r.sel] = 1'b0;
                    st_nxt.co.handler_mode = 1'b1;
                    st_nxt.co.cur_exc = st_r.sel;
                    st_nxt.co.entry_pulse = 1'b1;
                end
            end
            NIC_UNSTACK: begin
                if (core_stack_ack) begin
                    st_nxt.co.stack_word = st_r.co.stack_word + 3'h1;
                    if (st_r.co.stack_word == STACK_LAST) begin
                        st_nxt.co.unstack_req = 1'b0;
                        st_nxt.co.resume_pulse = 1'b1;
                        st_nxt.co.cur_exc = top_num;
                        st_nxt.co.handler_mode = |st_r.active;
                        st_nxt.phase = (|st_r.active) ? NIC_HANDLER
                                                      : NIC_IDLE;
                    end
                end
            end
        endcase

        // Hardware events pend last so a same-cycle clear cannot lose them.
        if (st_r.nmi_sync2) begin
            st_nxt.pend[EXC_NMI] = 1'b1;
        end
        if (hardfault_req) begin
            st_nxt.pend[EXC_HARDFAULT] = 1'b1;
        end
        if (svc_req) begin
            st_nxt.pend[EXC_SVC] = 1'b1;
        end
        if (pended_service_exception_set) begin
            st_nxt.pend[EXC_PENDED_SERVICE_EXCEPTION] = 1'b1;
        end
        if (tick_st.pend) begin
            st_nxt.pend[EXC_TICK] = 1'b1;
        end
        st_nxt.pend[EXC_EXT_BASE +: LINES] |= st_r.sync2 & LINE_USED_MASK;
    end

    // -------------------------------------------------------------------
    // Registers and outputs
    // -------------------------------------------------------------------
    // Registers the whole state; priorities reset to zero.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.phase <= NIC_IDLE;
            st_r.co.vec_addr <= VEC_SP_MAIN_ADDR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign enable_state = st_r.en;
    assign pending_state = st_r.pend[EXC_EXT_BASE +: LINES];
    assign prio_rdata = st_r.prio_rdata;
    assign wake_req = st_r.wake;
    assign core_out = st_r.co;
    assign tick_current = tick_st.cur;
    assign tick_wrap_flag = tick_st.flag;

endmodule : nic_irq_ctrl

// *** nic_irq_checker.sv ***
// Port-level assertions for the nested interrupt unit.
module nic_irq_checker
    import nic_pkg::*;
#(
    parameter int LINES = NIC_LINES
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire nic_tick_cfg_type tick_cfg,
    input wire logic tick_cur_wr,
    input wire logic tick_status_rd,
    input wire logic [LINES-1:0] pending_state,
    input wire logic wake_req,
    input wire nic_core_out_type core_out,
    input wire logic [TICK_W-1:0] tick_current,
    input wire logic tick_wrap_flag
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Counter runs on enabled edges without a value write.
    logic run;
    assign run = tick_cfg.enable && !tick_cur_wr;

    // -------------------------------------------------------------------
    // Tick counter
    // -------------------------------------------------------------------
    tick_dec_a: assert property (
        run && tick_current != TICK_ZERO |=>
        tick_current == $past(tick_current) - TICK_ONE)
        else $error("tick count did not step down");
    tick_clear_a: assert property (
        tick_cur_wr |=> tick_current == TICK_ZERO && !tick_wrap_flag)
        else $error("tick write did not clear");
    tick_reload_a: assert property (
        run && tick_current == TICK_ZERO |=>
        tick_current == $past(tick_cfg.reload))
        else $error("tick reload value not loaded");
    wrap_flag_a: assert property (
        run && tick_current == TICK_ONE |=> tick_wrap_flag)
        else $error("wrap flag not set at zero");
    flag_read_a: assert property (
        tick_status_rd && !(run && tick_current == TICK_ONE) |=>
        !tick_wrap_flag)
        else $error("wrap flag not cleared by read");

    // -------------------------------------------------------------------
    // Lines and exception entry
    // -------------------------------------------------------------------
    sequence s_entry_start;
        core_out.vec_req && core_out.stack_word == 3'h0;
    endsequence
    unused_line_a: assert property (
        (pending_state & ~LINES'(LINE_USED_MASK)) == '0)
        else $error("unused line shows pending");
    wake_src_a: assert property (
        wake_req |->
        |((pending_state | $past(pending_state)) & LINES'(WAKE_MASK)))
        else $error("wake raised without wake source");
    stack_start_a: assert property (
        $rose(core_out.stack_req) |-> s_entry_start)
        else $error("stacking began without vector fetch");
    entry_mode_a: assert property (
        core_out.entry_pulse |->
        core_out.handler_mode && core_out.cur_exc != EXC_NONE)
        else $error("handler entered outside handler mode");
    resume_a: assert property (
        core_out.resume_pulse |-> $past(core_out.unstack_req))
        else $error("resume without unstacking");
endmodule : nic_irq_checker

// *** nic_core_model.sv ***
// Core stand-in that acknowledges stacking words and vector fetches.
module nic_core_model
    import nic_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic slow,
    input wire nic_core_out_type core_out,
    output logic core_stack_ack,
    output logic core_vec_ack
);
    logic [1:0] wait_r;

    // One word per handshake; slow mode idles three cycles between words.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            core_stack_ack <= 1'b0;
            core_vec_ack <= 1'b0;
            wait_r <= 2'h0;
        end else begin
            core_stack_ack <= 1'b0;
            core_vec_ack <= 1'b0;
            if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else if (!core_stack_ack && !core_vec_ack) begin
                core_stack_ack <= core_out.stack_req || core_out.unstack_req;
                core_vec_ack <= core_out.vec_req;
                wait_r <= {slow, slow};
            end
        end
    end
endmodule : nic_core_model

// *** tb_top.sv ***
// Self-checking bench for the nested interrupt unit.
module tb_top
    import nic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0, rst_b = 1'b0, slow = 1'b0, tie0 = 1'b0;
    logic [31:0] irq_line = '0, enable_set = '0, enable_clr = '0;
    logic [31:0] pending_set = '0, pending_clr = '0;
    logic tick_cur_wr = 1'b0, tick_status_rd = 1'b0, ret = 1'b0;
    logic [3:0] prio_rd_idx = 4'h0;
    nic_prio_wr_type prio_wr = '0;
    nic_tick_cfg_type tick_cfg = '0;
    logic stk_ack, vec_ack, wake_req, tick_wrap_flag;
    logic [31:0] enable_state, pending_state, prio_rdata, last_vec;
    logic [23:0] tick_current;
    nic_core_out_type core_out;
    int n_fail = 0, n_compared = 0, n_stack = 0, s;

    // -------------------------------------------------------------------
    // Clock, design, core model
    // -------------------------------------------------------------------
    initial begin
        forever #20 clock = ~clock;
    end
    nic_irq_ctrl nic_irq_ctrl_i (.clock, .rst_b, .irq_line, .nmi_line(tie0),
        .hardfault_req(tie0), .svc_req(tie0), .pended_service_exception_set(tie0),
        .pended_service_exception_clr(tie0), .enable_set, .enable_clr, .pending_set,
        .pending_clr, .prio_wr, .prio_rd_idx, .tick_cfg, .tick_cur_wr,
        .tick_status_rd, .core_stack_ack(stk_ack), .core_vec_ack(vec_ack),
        .core_exc_return(ret), .enable_state, .pending_state, .prio_rdata,
        .wake_req, .core_out, .tick_current, .tick_wrap_flag);
    nic_core_model nic_core_model_i (.clock, .rst_b, .slow, .core_out,
        .core_stack_ack(stk_ack), .core_vec_ack(vec_ack));

    // Counts stack acks and keeps the last vector asked for.
    always @(posedge clock) begin
        if (stk_ack) n_stack++;
        if (core_out.vec_req) last_vec = core_out.vec_addr;
    end

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic pset(ref logic [31:0] sig, input logic [31:0] v);
        @(negedge clock);
        sig = v;
        @(negedge clock);
        sig = '0;
    endtask : pset
    task automatic prio_w(input logic [3:0] i, input logic [31:0] d);
        @(negedge clock);
        prio_wr = '{1'b1, i, d};
        @(negedge clock);
        prio_wr.wr = 1'b0;
    endtask : prio_w
    task automatic prio_r(input logic [3:0] i, input logic [31:0] e);
        @(negedge clock);
        prio_rd_idx = i;
        @(negedge clock);
        cmp("prio_rdata", e, prio_rdata);
    endtask : prio_r
    // Waits a bounded time for handler entry or for resume.
    task automatic waitp(input bit rsm);
        int k;
        k = 0;
        while ((rsm ? core_out.resume_pulse : core_out.entry_pulse) !== 1'b1
               && k < 300) begin
            @(negedge clock);
            k++;
        end
        cmp("pulse wait", 32'h1, 32'(k < 300));
    endtask : waitp
    task automatic ret_h;
        @(negedge clock);
        ret = 1'b1;
        @(negedge clock);
        ret = 1'b0;
    endtask : ret_h
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    // -------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        prio_r(4'h0, 32'h0);
        prio_r(4'h8, 32'h0);
        prio_w(4'h0, 32'h000000C0);
        prio_w(4'h1, 32'hFFFFFFFF);
        prio_r(4'h0, 32'h000000C0);
        prio_r(4'h1, 32'hC0C0C0C0);
        pset(pending_set, 32'h00030008);
        cmp("pending", 32'h8, pending_state);
        repeat (3) @(negedge clock);
        cmp("mode", 32'h0, core_out.handler_mode);
        cmp("wake", 32'h1, wake_req);
        pset(pending_clr, 32'h8);
        cmp("pending", 32'h0, pending_state);
        pset(enable_set, 32'h13);
        cmp("enable", 32'h13, enable_state);
        s = n_stack;
        irq_line[0] = 1'b1;
        repeat (3) @(negedge clock);
        irq_line[0] = 1'b0;
        waitp(1'b0);
        cmp("exc", 32'h10, core_out.cur_exc);
        cmp("stacked", 32'h8, 32'(n_stack - s));
        cmp("vector", 32'h40, last_vec);
        pset(pending_set, 32'h10);
        repeat (4) @(negedge clock);
        cmp("exc", 32'h10, core_out.cur_exc);
        slow = 1'b1;
        pset(pending_set, 32'h2);
        waitp(1'b0);
        cmp("exc", 32'h11, core_out.cur_exc);
        s = n_stack;
        ret_h;
        waitp(1'b1);
        cmp("unstacked", 32'h8, 32'(n_stack - s));
        cmp("mode", 32'h1, core_out.handler_mode);
        ret_h;
        waitp(1'b0);
        cmp("exc", 32'h14, core_out.cur_exc);
        cmp("chained", 32'h0, 32'(n_stack - s - 8));
        cmp("vector", 32'h50, last_vec);
        ret_h;
        waitp(1'b1);
        cmp("mode", 32'h0, core_out.handler_mode);
        @(negedge clock);
        tick_cfg = '{1'b1, 1'b0, 24'h000003};
        tick_cur_wr = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clock);
            tick_cur_wr = 1'b0;
            cmp("tick", 32'((i == 0) ? 0 : (i == 5) ? 3 : 4 - i),
                tick_current);
            if (i == 4) cmp("flag", 32'h1, tick_wrap_flag);
        end
        tick_status_rd = 1'b1;
        @(negedge clock);
        tick_status_rd = 1'b0;
        cmp("flag", 32'h0, tick_wrap_flag);
        tick_cfg.reload = 24'h0;
        repeat (5) @(negedge clock);
        cmp("tick", 32'h0, tick_current);
        tick_cfg = '{1'b1, 1'b1, 24'h000002};
        repeat (3) @(negedge clock);
        tick_cfg = '0;
        waitp(1'b0);
        cmp("exc", 32'h0F, core_out.cur_exc);
        ret_h;
        waitp(1'b1);
        pset(enable_clr, 32'h13);
        cmp("enable", 32'h0, enable_state);
        stop_test;
    end

    // Ends a hung run.
    initial begin
        #(40 * 5000);
        cmp("watchdog", 32'h0, 32'h1);
        stop_test;
    end
endmodule : tb_top

bind nic_irq_ctrl nic_irq_checker #(.LINES(LINES)) nic_irq_checker_i (.clock,
    .rst_b, .tick_cfg, .tick_cur_wr, .tick_status_rd, .pending_state,
    .wake_req, .core_out, .tick_current, .tick_wrap_flag);
